// ===== dra_pkg.sv
// Shared constants, field layouts and types of the four-channel DMA request block.
// Assumes a 32-bit APB register bus and a 16-bit system bus master port.
package dra_pkg;
   localparam int NUM_CH  = 4;
   localparam int ADDR_W  = 24;
   localparam int COUNT_W = 16;
   localparam int DATA_W  = 16;

   // APB byte address: channel block at ch * CH_STRIDE, word index inside it
   localparam logic [7:0] CH_STRIDE   = 8'h20;
   localparam logic [2:0] REG_CTRL_A  = 3'h0;
   localparam logic [2:0] REG_CTRL_B  = 3'h1;
   localparam logic [2:0] REG_MPTR    = 3'h2;
   localparam logic [2:0] REG_PADDR   = 3'h3;
   localparam logic [2:0] REG_COUNT   = 3'h4;
   localparam logic [7:0] ADDR_OP_CTRL = 8'h80;
   localparam logic [7:0] ADDR_STATUS  = 8'h84;

   localparam int OP_DE_LSB      = 0;
   localparam int OP_WE_LSB      = 8;
   localparam int CTRL_B_BERR    = 7;
   localparam int STAT_BUSY      = 0;
   localparam int STAT_CH_LSB    = 4;
   localparam int CTRL_A_W       = 10;

   localparam logic [2:0] RC_SINGLE_NORMAL = 3'h0;
   localparam logic [2:0] RC_SINGLE_CONT   = 3'h1;
   localparam logic [2:0] RC_DUAL_PIN      = 3'h4;
   localparam logic [2:0] RC_DUAL_SERIAL   = 3'h5;
   localparam logic [2:0] RC_DUAL_TIMER    = 3'h6;
   localparam logic [2:0] RC_AUTO          = 3'h7;

   localparam logic [1:0] DRC_INC   = 2'h0;
   localparam logic [1:0] DRC_DEC   = 2'h1;
   localparam logic [1:0] DRC_FIXED = 2'h2;

   localparam logic [ADDR_W-1:0]  STEP_BYTE  = 24'h000001;
   localparam logic [ADDR_W-1:0]  STEP_WORD  = 24'h000002;
   localparam logic [COUNT_W-1:0] COUNT_ZERO = 16'h0000;
   localparam logic [COUNT_W-1:0] COUNT_ONE  = 16'h0001;

   // Channel control A, packed MSB first into bits 9:0 of its word
   typedef struct packed {
      logic       mrc;
      logic [2:0] requester_class;
      logic       dps;
      logic       ops;
      logic       request_sense_flag;
      logic       bus_mode_bit;
      logic       dir;
      logic       prio_express;
   } dra_ctrl_a_t;

   localparam dra_ctrl_a_t CTRL_A_RESET = '0;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              rd;
      logic              wr;
      logic              byte_size;
   } dra_sys_req_t;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_REQ   = 3'b001,
      ST_READ  = 3'b011,
      ST_WRITE = 3'b010,
      ST_GAP   = 3'b110
   } dra_state_t;
endpackage

// ===== dra_arb.sv
// Channel priority arbiter: express channels first, then lowest channel number.
// Assumes requests are already qualified by enable and source selection.
`timescale 1ns/1ps
module dra_arb #(
   parameter int N = 4
) (
   input  wire logic [N-1:0]         req,
   input  wire logic [N-1:0]         express,
   output logic                      any,
   output logic [$clog2(N)-1:0]      win
);
   always_comb begin
      any = |req;
      win = '0;
      for (int i = N - 1; i >= 0; i--) begin
         if (req[i] && !express[i]) begin
            win = i[$clog2(N)-1:0];
         end
      end
      // Express pass last so it overrides normal winners
      for (int i = N - 1; i >= 0; i--) begin
         if (req[i] && express[i]) begin
            win = i[$clog2(N)-1:0];
         end
      end
   end
endmodule // dra_arb

// ===== dra_top.sv
// Four-channel DMA request handling and transfer sequencing with APB registers.
// Assumes a CPU-side bus arbiter answering bus_request with bus_grant and a
// system bus that ends every access with sys_ready, flagging errors on sys_error.
//
// Summary of operation
// - Auto mode transfers continuously until transfer count reaches zero.
// - Requester class 111 selects auto; requests generated while channel enabled.
// - External mode moves one byte or word per request, pin or internal.
// - External requests honoured only when enabled; count zero clears enable.
// - A source's request counts only when requester class selects that source.
// - Level mode samples request each clock outside DMA cycles; raises bus request.
// - Request gone two clocks before start cancels; one clock before still runs.
// - Simultaneous channel requests resolved by channel priority arbitration.
// - Request seen at access end keeps bus; cycle steal releases once per transfer.
// - Edge mode: falling request edge starts one transfer; extra edges merge.
// - Edge sampling each clock outside, at access end inside DMA cycles.
// - Single-address targets external memory with ack I/O; dual reaches any address.
// - Ack devices: byte on 8-bit, word on 16-bit; dual: byte or word by size.
// - Single-address transfer accesses source and destination in one bus cycle.
// - Single-address device selected by active-low ack answering its request.
// - Each transfer decrements count, steps memory pointer, dual steps peripheral.
// - Clearing channel enable early suspends that channel.
// - Single-address runs only on external requests, obedient or cycle steal.
// - Dual transfer: read then write, data buffered, bus held between.
// - Error during dual read suppresses the write cycle.
// - Dual accepts external and auto; burst, steal, obedient; auto starts on enable.
// - Class codes: 000/001 single pin, 100 pin, 101 serial, 110 timer, 111 auto.
// - Request sense zero is level, one is edge; resets to zero.
// - Bus mode one is cycle steal; zero is obedient or burst.
// - Direction zero memory to device, one device to memory.
//
// Register access over APB and the address map were left to the implementer.
`timescale 1ns/1ps
module dra_top
(
   input  wire logic                            pclk,
   input  wire logic                            presetn,
   input  wire logic                            psel,
   input  wire logic                            penable,
   input  wire logic                            pwrite,
   input  wire logic [7:0]                      paddr,
   input  wire logic [31:0]                     pwdata,
   output logic [31:0]                          prdata,
   output logic                                 pready,
   output logic                                 pslverr,
   input  wire logic [dra_pkg::NUM_CH-1:0]      transfer_request_line_n,
   input  wire logic [dra_pkg::NUM_CH-1:0]      serial_unit_req,
   input  wire logic [dra_pkg::NUM_CH-1:0]      timer_req,
   output logic                                 bus_request,
   input  wire logic                            bus_grant,
   output dra_pkg::dra_sys_req_t                sys_req,
   input  wire logic [dra_pkg::DATA_W-1:0]      sys_rdata,
   input  wire logic                            sys_ready,
   input  wire logic                            sys_error,
   output logic [dra_pkg::NUM_CH-1:0]           transfer_ack_line_n
);
   import dra_pkg::*;
   localparam int CW = $clog2(NUM_CH);

   dra_ctrl_a_t         ctrl_a      [NUM_CH];
   logic [1:0]          drc         [NUM_CH];
   logic [ADDR_W-1:0]   memory_pointer     [NUM_CH];
   logic [ADDR_W-1:0]   peripheral_address [NUM_CH];
   logic [COUNT_W-1:0]  transfer_count     [NUM_CH];
   logic [NUM_CH-1:0]   channel_enable_bit;
   logic [NUM_CH-1:0]   bus_error;
   logic [NUM_CH-1:0]   req_raw;
   logic [NUM_CH-1:0]   req_lvl;
   logic [NUM_CH-1:0]   req_prev;
   logic [NUM_CH-1:0]   edge_pend;
   logic [NUM_CH-1:0]   elig;
   logic [NUM_CH-1:0]   express;
   logic [NUM_CH-1:0]   start_vec;
   logic                any_elig;
   logic [CW-1:0]       win;
   logic [CW-1:0]       cur;
   dra_state_t          state;
   logic                sample_en;
   logic                start;
   logic                xfer_done;
   logic                xfer_err;
   logic                cur_single;
   logic                steal;
   dra_sys_req_t        next_first;
   dra_sys_req_t        next_write;

   function automatic logic is_single(input logic [2:0] rc);
      return (rc == RC_SINGLE_NORMAL) || (rc == RC_SINGLE_CONT);
   endfunction

   // Byte transfer: 8-bit port, or 16-bit port with byte operand in dual mode
   function automatic logic is_byte(input dra_ctrl_a_t c);
      return c.dps || (!is_single(c.requester_class) && c.ops);
   endfunction

   function automatic logic [ADDR_W-1:0] step(input logic [ADDR_W-1:0] a,
                                              input logic [ADDR_W-1:0] s,
                                              input logic [1:0] mode);
      unique case (mode)
         DRC_INC: return a + s;
         DRC_DEC: return a - s;
         default: return a;
      endcase
   endfunction

   // Source selection per requester class; reserved codes never request
   always_comb begin
      for (int c = 0; c < NUM_CH; c++) begin
         unique case (ctrl_a[c].requester_class)
            RC_SINGLE_NORMAL, RC_SINGLE_CONT, RC_DUAL_PIN:
               req_raw[c] = ~transfer_request_line_n[c];
            RC_DUAL_SERIAL: req_raw[c] = serial_unit_req[c];
            RC_DUAL_TIMER:  req_raw[c] = timer_req[c];
            default:        req_raw[c] = 1'b0;
         endcase
         express[c] = ctrl_a[c].prio_express;
      end
   end

   // Outside DMA accesses sample every clock; inside only at the access end
   assign sample_en = !((state == ST_READ) || (state == ST_WRITE)) || sys_ready;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {req_lvl, req_prev} <= '0;
      end else if (sample_en) begin
         {req_lvl, req_prev} <= {req_raw, req_lvl};
      end
   end

   // Edge pending: a new edge wins over the consume in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         edge_pend <= '0;
      end else begin
         for (int c = 0; c < NUM_CH; c++) begin
            if (sample_en && req_lvl[c] && !req_prev[c]) begin
               edge_pend[c] <= 1'b1;
            end else if (start_vec[c] || !channel_enable_bit[c]) begin
               edge_pend[c] <= 1'b0;
            end
         end
      end
   end

   always_comb begin
      for (int c = 0; c < NUM_CH; c++) begin
         if (ctrl_a[c].requester_class == RC_AUTO) begin
            elig[c] = channel_enable_bit[c];
         end else if (ctrl_a[c].request_sense_flag) begin
            elig[c] = channel_enable_bit[c] && edge_pend[c];
         end else begin
            // Registered sample makes a one-clock-late withdrawal still run
            elig[c] = channel_enable_bit[c] && req_lvl[c];
         end
         start_vec[c] = start && (win == c[CW-1:0]);
      end
   end

   dra_arb #(.N(NUM_CH)) u_arb (
      .req     (elig),
      .express (express),
      .any     (any_elig),
      .win     (win)
   );

   assign start      = (state == ST_REQ) && any_elig && bus_grant;
   assign cur_single = is_single(ctrl_a[cur].requester_class);
   assign xfer_err   = ((state == ST_READ) || (state == ST_WRITE)) && sys_ready && sys_error;
   assign xfer_done  = sys_ready && !sys_error &&
                       ((state == ST_WRITE) || ((state == ST_READ) && cur_single));
   // Burst exists only for auto requests; external with bus mode 0 is obedient
   assign steal      = ctrl_a[cur].bus_mode_bit;

   always_comb begin
      next_first           = '0;
      next_first.byte_size = is_byte(ctrl_a[win]);
      if (is_single(ctrl_a[win].requester_class)) begin
         next_first.addr = memory_pointer[win];
         next_first.rd   = !ctrl_a[win].dir;
         next_first.wr   = ctrl_a[win].dir;
      end else begin
         next_first.addr = ctrl_a[win].dir ? peripheral_address[win]
                                           : memory_pointer[win];
         next_first.rd   = 1'b1;
      end
   end

   always_comb begin
      next_write           = '0;
      next_write.byte_size = is_byte(ctrl_a[cur]);
      next_write.addr      = ctrl_a[cur].dir ? memory_pointer[cur]
                                             : peripheral_address[cur];
      next_write.wdata     = sys_rdata;
      next_write.wr        = 1'b1;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state               <= ST_IDLE;
         cur                 <= '0;
         bus_request         <= 1'b0;
         sys_req             <= '0;
         transfer_ack_line_n <= '1;
      end else begin
         unique case (state)
            ST_IDLE: begin
               if (any_elig) begin
                  bus_request <= 1'b1;
                  state       <= ST_REQ;
               end
            end
            ST_REQ: begin
               if (!any_elig) begin
                  bus_request <= 1'b0;
                  state       <= ST_IDLE;
               end else if (bus_grant) begin
                  cur     <= win;
                  sys_req <= next_first;
                  if (is_single(ctrl_a[win].requester_class)) begin
                     transfer_ack_line_n[win] <= 1'b0;
                  end
                  state <= ST_READ;
               end
            end
            ST_READ: begin
               if (sys_ready) begin
                  if (sys_error) begin
                     sys_req             <= '0;
                     transfer_ack_line_n <= '1;
                     bus_request         <= 1'b0;
                     state               <= ST_IDLE;
                  end else if (cur_single) begin
                     sys_req             <= '0;
                     transfer_ack_line_n <= '1;
                     bus_request         <= !steal;
                     state               <= steal ? ST_GAP : ST_REQ;
                  end else begin
                     sys_req  <= next_write;
                     state    <= ST_WRITE;
                  end
               end
            end
            ST_WRITE: begin
               if (sys_ready) begin
                  sys_req     <= '0;
                  bus_request <= !steal && !sys_error;
                  state       <= sys_error ? ST_IDLE : (steal ? ST_GAP : ST_REQ);
               end
            end
            ST_GAP: begin
               // One released state lets another master take the bus
               state <= ST_IDLE;
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // Channel registers: software writes and per-transfer updates
   wire logic          apb_wr = psel && penable && pready && pwrite && !pslverr;
   wire logic [CW-1:0] a_ch   = paddr[6:5];
   wire logic [2:0]    a_idx  = paddr[4:2];
   wire logic          a_chan = !paddr[7] && (a_idx <= REG_COUNT);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int c = 0; c < NUM_CH; c++) begin
            ctrl_a[c]             <= CTRL_A_RESET;
            drc[c]                <= DRC_INC;
            memory_pointer[c]     <= '0;
            peripheral_address[c] <= '0;
            transfer_count[c]     <= COUNT_ZERO;
         end
      end else begin
         if (apb_wr && a_chan) begin
            unique case (a_idx)
               REG_CTRL_A: ctrl_a[a_ch]             <= pwdata[CTRL_A_W-1:0];
               REG_CTRL_B: drc[a_ch]                <= pwdata[1:0];
               REG_MPTR:   memory_pointer[a_ch]     <= pwdata[ADDR_W-1:0];
               REG_PADDR:  peripheral_address[a_ch] <= pwdata[ADDR_W-1:0];
               default:    transfer_count[a_ch]     <= pwdata[COUNT_W-1:0];
            endcase
         end
         if (xfer_done) begin
            transfer_count[cur] <= transfer_count[cur] - COUNT_ONE;
            memory_pointer[cur] <= step(memory_pointer[cur],
                                        is_byte(ctrl_a[cur]) ? STEP_BYTE : STEP_WORD,
                                        ctrl_a[cur].mrc ? DRC_DEC : DRC_INC);
            if (!cur_single) begin
               // Byte operands on an 8-bit port skip odd device addresses
               peripheral_address[cur] <= step(peripheral_address[cur],
                  (ctrl_a[cur].dps || !is_byte(ctrl_a[cur])) ? STEP_WORD : STEP_BYTE,
                  drc[cur]);
            end
         end
      end
   end

   // Operation control: enable guarded by write-enable bits; hardware clear wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         channel_enable_bit <= '0;
      end else begin
         for (int c = 0; c < NUM_CH; c++) begin
            if (apb_wr && (paddr == ADDR_OP_CTRL) && pwdata[OP_WE_LSB + c]) begin
               channel_enable_bit[c] <= pwdata[OP_DE_LSB + c];
            end
            if ((xfer_done && (cur == c[CW-1:0]) && (transfer_count[c] == COUNT_ONE)) ||
                (xfer_err && (cur == c[CW-1:0]))) begin
               channel_enable_bit[c] <= 1'b0;
            end
         end
      end
   end

   // Bus error flags: set wins over write-one-to-clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bus_error <= '0;
      end else begin
         for (int c = 0; c < NUM_CH; c++) begin
            if (xfer_err && (cur == c[CW-1:0])) begin
               bus_error[c] <= 1'b1;
            end else if (apb_wr && a_chan && (a_idx == REG_CTRL_B) && (a_ch == c[CW-1:0])
                         && pwdata[CTRL_B_BERR]) begin
               bus_error[c] <= 1'b0;
            end
         end
      end
   end

   // APB slave: answer in the first access cycle, no wait states
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= '0;
      end else begin
         pready  <= psel && !penable;
         pslverr <= 1'b0;
         prdata  <= '0;
         if (psel && !penable) begin
            if (paddr[1:0] != 2'b00) begin
               pslverr <= 1'b1;
            end else if (a_chan) begin
               unique case (a_idx)
                  REG_CTRL_A: prdata[CTRL_A_W-1:0] <= ctrl_a[a_ch];
                  REG_CTRL_B: begin
                     prdata[1:0]         <= drc[a_ch];
                     prdata[CTRL_B_BERR] <= bus_error[a_ch];
                  end
                  REG_MPTR:   prdata[ADDR_W-1:0]  <= memory_pointer[a_ch];
                  REG_PADDR:  prdata[ADDR_W-1:0]  <= peripheral_address[a_ch];
                  default:    prdata[COUNT_W-1:0] <= transfer_count[a_ch];
               endcase
            end else if (paddr == ADDR_OP_CTRL) begin
               prdata[OP_DE_LSB +: NUM_CH] <= channel_enable_bit;
            end else if (paddr == ADDR_STATUS) begin
               prdata[STAT_BUSY]          <= (state != ST_IDLE);
               prdata[STAT_CH_LSB +: CW]  <= cur;
            end else begin
               pslverr <= 1'b1;
            end
         end
      end
   end
endmodule // dra_top

// ===== dra_monitor.sv
// Concurrent checks on the system-bus side of the DMA request block.
// Assumes it is bound to dra_top and sees only its ports.
`timescale 1ns/1ps
module dra_monitor
(
   input wire logic                       pclk,
   input wire logic                       presetn,
   input wire logic                       bus_request,
   input wire logic                       bus_grant,
   input wire dra_pkg::dra_sys_req_t      sys_req,
   input wire logic [dra_pkg::DATA_W-1:0] sys_rdata,
   input wire logic                       sys_ready,
   input wire logic                       sys_error,
   input wire logic [dra_pkg::NUM_CH-1:0] transfer_ack_line_n
);
   import dra_pkg::*;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire logic acc = sys_req.rd | sys_req.wr;
   ack_onehot_a: assert property ($onehot0(~transfer_ack_line_n))
      else $error("more than one acknowledge low");
   ack_in_access_a: assert property (transfer_ack_line_n != 4'hF |-> acc)
      else $error("acknowledge low outside an access");
   grant_first_a: assert property ($rose(sys_req.rd) |-> $past(bus_grant) && $past(bus_request))
      else $error("access started without bus grant");
   access_hold_a: assert property (acc && !sys_ready |=> $stable(sys_req))
      else $error("access changed before ready");
   single_done_a: assert property (transfer_ack_line_n != 4'hF && sys_ready |=> transfer_ack_line_n == 4'hF)
      else $error("single transfer took more than one cycle");
   read_write_a: assert property (sys_req.rd && sys_ready && !sys_error && transfer_ack_line_n == 4'hF
      |=> sys_req.wr && sys_req.wdata == $past(sys_rdata))
      else $error("dual read not followed by write of its data");
   no_write_err_a: assert property (sys_req.rd && sys_ready && sys_error |=> !sys_req.wr)
      else $error("write issued after failed read");
   write_ends_a: assert property (sys_req.wr && sys_ready && transfer_ack_line_n == 4'hF |=> !acc)
      else $error("dual write not followed by a free cycle");
endmodule // dra_monitor
bind dra_top dra_monitor dra_monitor_i (.pclk(pclk), .presetn(presetn), .bus_request(bus_request),
   .bus_grant(bus_grant), .sys_req(sys_req), .sys_rdata(sys_rdata), .sys_ready(sys_ready),
   .sys_error(sys_error), .transfer_ack_line_n(transfer_ack_line_n));

// ===== dra_sysmem.sv
// Behavioural system bus: arbiter, memory and one address whose reads answer with an error.
// Assumes the DMA block holds each access until sys_ready.
`timescale 1ns/1ps
module dra_sysmem
(
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   input  wire logic                  bus_request,
   output logic                       bus_grant,
   input  wire dra_pkg::dra_sys_req_t sys_req,
   output logic [dra_pkg::DATA_W-1:0] sys_rdata,
   output logic                       sys_ready,
   output logic                       sys_error,
   input  wire logic [1:0]            slow,
   input  wire logic [7:0]            err_addr
);
   import dra_pkg::*;
   logic [15:0] mem [0:255];
   logic [1:0]  cnt;
   wire  [7:0]  a = sys_req.addr[7:0];
   wire         acc = sys_req.rd | sys_req.wr;
   initial for (int i = 0; i < 256; i++) mem[i] = 16'(i * 16'h0131);
   // Released data bus shows the inverse so a stale value never looks valid
   assign sys_rdata = sys_ready ? mem[a] : ~mem[a];
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) bus_grant <= 1'b0;
      else bus_grant <= bus_request;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt       <= 2'h0;
         sys_ready <= 1'b0;
         sys_error <= 1'b0;
      end else begin
         sys_ready <= acc & !sys_ready & (cnt == slow);
         sys_error <= sys_req.rd & (a == err_addr);
         cnt       <= (acc & !sys_ready & (cnt != slow)) ? cnt + 2'h1 : 2'h0;
      end
   end
   always @(posedge pclk) if (sys_ready & sys_req.wr) mem[a] <= sys_req.wdata;
endmodule // dra_sysmem

// ===== dma_request_and_transfer_modes_tb.sv
// Self-checking bench: register access, auto, pin, serial, timer edge and error transfers.
// Assumes dra_top with dra_sysmem standing in for the system bus and memory.
`timescale 1ns/1ps
module dma_request_and_transfer_modes_tb;
   import dra_pkg::*;
   logic         pclk, presetn, psel, penable, pwrite, pready, pslverr, perr;
   logic         bus_request, bus_grant, sys_ready, sys_error;
   logic [7:0]   paddr, err_addr;
   logic [31:0]  pwdata, prdata, rd;
   logic [3:0]   pin_n, ser, tmr, ack_n;
   logic [15:0]  sys_rdata;
   logic [1:0]   slow;
   dra_sys_req_t sys_req;
   int           failures, total_checks, cyc, xfers;
   dra_top dra_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .transfer_request_line_n(pin_n), .serial_unit_req(ser),
      .timer_req(tmr), .bus_request(bus_request), .bus_grant(bus_grant), .sys_req(sys_req),
      .sys_rdata(sys_rdata), .sys_ready(sys_ready), .sys_error(sys_error),
      .transfer_ack_line_n(ack_n));
   dra_sysmem dra_sysmem_i (.pclk(pclk), .presetn(presetn), .bus_request(bus_request),
      .bus_grant(bus_grant), .sys_req(sys_req), .sys_rdata(sys_rdata), .sys_ready(sys_ready),
      .sys_error(sys_error), .slow(slow), .err_addr(err_addr));
   initial begin
      pclk = 0;
      forever #20 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (sys_ready && (ack_n != 4'hF || sys_req.wr)) xfers <= xfers + 1;
      if (cyc == 30000) begin
         failures++;
         wrap_up();
      end
   end
   task automatic check(string what, logic [31:0] got, logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
      @(posedge pclk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      perr = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task automatic cfg(int ch, logic [31:0] ca, logic [31:0] mp, logic [31:0] pa, logic [31:0] n);
      apb(1, 8'(ch * 32), ca);
      apb(1, 8'(ch * 32 + 8), mp);
      apb(1, 8'(ch * 32 + 12), pa);
      apb(1, 8'(ch * 32 + 16), n);
   endtask
   task automatic wait_done();
      repeat (6) @(posedge pclk);
      do apb(0, ADDR_STATUS, 0); while (rd[0] !== 1'b0);
   endtask
   function automatic logic [31:0] orig(int i);
      return 32'(16'(i * 16'h0131));
   endfunction
   task automatic t_regs();
      apb(0, 8'h00, 0);
      check("ctrl_a reset", rd, 0);
      apb(0, 8'h88, 0);
      check("unmapped error", 32'(perr), 1);
   endtask
   task automatic t_auto();
      cfg(0, 32'h1C0, 32'h10, 32'h40, 3);
      apb(1, ADDR_OP_CTRL, 32'h101);
      wait_done();
      for (int i = 0; i < 4; i++)
         check("auto copy", 32'(dra_sysmem_i.mem[64 + 2 * i]), orig(i < 3 ? 16 + 2 * i : 70));
      apb(0, 8'h10, 0);
      check("auto count", rd, 0);
      apb(0, 8'h08, 0);
      check("auto mptr", rd, 32'h16);
      apb(0, 8'h0C, 0);
      check("auto paddr", rd, 32'h46);
      apb(0, ADDR_OP_CTRL, 0);
      check("auto enable", 32'(rd[0]), 0);
   endtask
   task automatic t_pin();
      int x0;
      x0 = xfers;
      pin_n <= 4'hD;
      cfg(1, 32'h222, 32'h20, 32'h0, 2);
      check("request while off", 32'(bus_request), 0);
      apb(1, ADDR_OP_CTRL, 32'h202);
      wait_done();
      pin_n <= 4'hF;
      check("single count", 32'(xfers - x0), 2);
      apb(0, 8'h28, 0);
      check("single mptr", rd, 32'h1E);
   endtask
   task automatic t_serial();
      int x0;
      x0 = xfers;
      slow <= 2;
      tmr <= 4'h4;
      cfg(2, 32'h144, 32'h30, 32'h90, 1);
      apb(1, ADDR_OP_CTRL, 32'h404);
      repeat (20) @(posedge pclk);
      check("other source", 32'(bus_request), 0);
      tmr <= 0;
      ser <= 4'h4;
      wait_done();
      ser <= 0;
      check("serial count", 32'(xfers - x0), 1);
   endtask
   task automatic t_edge();
      int x0;
      cfg(2, 32'h198, 32'h30, 32'hA0, 4);
      apb(1, 8'h44, 32'h1);
      apb(1, ADDR_OP_CTRL, 32'h404);
      x0 = xfers;
      for (int i = 0; i < 4; i++) begin
         @(posedge pclk);
         tmr <= {1'b0, ~i[0], 2'h0};
      end
      repeat (40) @(posedge pclk);
      check("edge merge", 32'(xfers - x0), 1);
      apb(0, 8'h4C, 0);
      check("edge paddr", rd, 32'h9F);
   endtask
   task automatic t_err();
      int x0;
      x0 = xfers;
      slow <= 0;
      err_addr <= 8'h50;
      cfg(3, 32'h1C0, 32'h50, 32'h60, 2);
      apb(1, ADDR_OP_CTRL, 32'h808);
      wait_done();
      check("no write", 32'(dra_sysmem_i.mem[96]), orig(96));
      check("error xfers", 32'(xfers - x0), 0);
      apb(0, 8'h64, 0);
      check("error flag", 32'(rd[CTRL_B_BERR]), 1);
   endtask
   task automatic wrap_up();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial begin
      {psel, penable, pwrite, paddr, pwdata, ser, tmr, slow} = '0;
      {failures, total_checks, cyc, xfers} = '0;
      pin_n = 4'hF;
      err_addr = 8'hFF;
      presetn = 0;
      repeat (12) @(posedge pclk);
      presetn <= 1;
      t_regs();
      t_auto();
      t_pin();
      t_serial();
      t_edge();
      t_err();
      wrap_up();
   end
endmodule // dma_request_and_transfer_modes_tb
